// >>> rtl/adcs_top.sv
/*
 * Converter digital core: starts a conversion on each rising edge of the
 * conversion strobe outside a conversion, takes the sample from a FIFO, and shifts the result
 * out on SDO clocked by the host's SCK.
 * Assumes the host keeps SCK still during conversion and quiet windows;
 * SCK clocks its own domain, crossing by gray count and held result word.
 */
// Functional notes
// RULE_01 - Strobe rise starts conversion, ready 270-320 ns
// RULE_02 - Host leaves enough acquisition time between conversions
// RULE_03 - Host holds strobe high long enough
// RULE_04 - Host keeps SCK quiet 190 ns after strobe
// RULE_05 - Host ends SCK 60 ns before next strobe
// RULE_06 - Strobe or SDI low drives MSB on SDO
// RULE_07 - Strobe and SDI high, or done: release SDO
// RULE_08 - Next bit follows each SCK falling edge
// RULE_09 - Daisy-chain SCK period at least 20 ns
// RULE_10 - Full throughput needs overlapped mode, fast SCK; SDO here drives only in ADCS_READY, after conversion, so no overlap
// RULE_11 - Sixteen bits, MSB first, LSB last
`timescale 1ns/100ps
`include "adcs_cfg.svh"

module adcs_top #(
    parameter int FIFO_DEPTH = `ADCS_FIFO_DEPTH
) (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link clock from the host
    input wire logic sck_i,
    // Host pins
    input wire adcs_pkg::adcs_pins_s pins_i,
    output adcs_pkg::adcs_sdo_s sdo_o,
    // Sample source
    input wire logic sample_valid_i,
    input wire adcs_pkg::adcs_word_t sample_data_i,
    output logic sample_ready_o,
    // Status
    output logic conv_busy_o,
    output logic result_ready_o,
    output logic underrun_o
);
    import adcs_pkg::*;

    localparam int CONV_C = `ADCS_CONV_CYCLES;
    localparam int NBITS = `ADCS_RESULT_BITS;

    // Input synchronisers, system domain
    logic strb_s1_reg, strb_s2_reg, strb_s3_reg;
    logic sdi_s1_reg, sdi_s2_reg;
    logic strb_rise;

    // Conversion
    adcs_conv_e state_reg;
    logic [7:0] conv_cnt_reg;
    adcs_word_t sample_reg;
    adcs_word_t word_reg;
    logic fifo_valid;
    adcs_word_t fifo_data;
    logic fifo_in_ready;
    logic underrun_reg;

    // Falling-edge count crossing
    adcs_cnt_t fall_cnt_reg;
    adcs_cnt_t fall_gray_reg;
    adcs_cnt_t gray_s1_reg, gray_s2_reg;
    adcs_cnt_t base_reg;
    adcs_cnt_t falls;
    logic oe_n_reg;
    logic msb_reg;

    // Link domain
    logic rst_sck_s1_reg, rst_sck_s2_reg;
    logic sdo_fall_reg;
    adcs_cnt_t idx_next;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            strb_s1_reg <= 1'b0;
            strb_s2_reg <= 1'b0;
            strb_s3_reg <= 1'b0;
            sdi_s1_reg <= 1'b1;
            sdi_s2_reg <= 1'b1;
        end
        else
        begin
            strb_s1_reg <= pins_i.conversion_strobe;
            strb_s2_reg <= strb_s1_reg;
            strb_s3_reg <= strb_s2_reg;
            sdi_s1_reg <= pins_i.sdi;
            sdi_s2_reg <= sdi_s1_reg;
        end
    end

    assign strb_rise = strb_s2_reg && !strb_s3_reg;

    adcs_fifo #(
        .WIDTH(NBITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(sample_valid_i),
        .in_data_i(sample_data_i),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(strb_rise && state_reg != ADCS_CONVERT)
    );

    // Ready toward the source, registered
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sample_ready_o <= 1'b0;
        end
        else
        begin
            sample_ready_o <= fifo_in_ready;
        end
    end

    // Conversion sequencer; a rise during conversion is ignored
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_reg <= ADCS_IDLE;
            conv_cnt_reg <= '0;
            sample_reg <= '0;
            word_reg <= '0;
            underrun_reg <= 1'b0;
            conv_busy_o <= 1'b0;
            result_ready_o <= 1'b0;
        end
        else
        begin
            underrun_reg <= 1'b0;
            unique case (state_reg)
                ADCS_IDLE, ADCS_READY:
                begin
                    if (strb_rise) // [RULE_01]
                    begin
                        state_reg <= ADCS_CONVERT;
                        conv_busy_o <= 1'b1;
                        result_ready_o <= 1'b0;
                        conv_cnt_reg <= 8'(CONV_C - 1);
                        if (fifo_valid)
                        begin
                            sample_reg <= fifo_data;
                        end
                        else
                        begin
                            underrun_reg <= 1'b1;
                        end
                    end
                end
                ADCS_CONVERT:
                begin
                    if (conv_cnt_reg == '0) // [RULE_01]
                    begin
                        state_reg <= ADCS_READY;
                        conv_busy_o <= 1'b0;
                        result_ready_o <= 1'b1;
                        word_reg <= sample_reg;
                    end
                    else
                    begin
                        conv_cnt_reg <= conv_cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    assign underrun_o = underrun_reg;

    // Reset into the link domain; only acts while SCK runs
    always_ff @(negedge sck_i)
    begin
        rst_sck_s1_reg <= rst_i;
        rst_sck_s2_reg <= rst_sck_s1_reg;
    end

    // Falling-edge count and data bit; word_reg is held while SCK runs
    assign idx_next = fall_cnt_reg + 1'b1 - base_reg;

    always_ff @(negedge sck_i)
    begin
        if (rst_sck_s2_reg)
        begin
            fall_cnt_reg <= '0;
            fall_gray_reg <= '0;
            sdo_fall_reg <= 1'b0;
        end
        else
        begin
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
            fall_gray_reg <= adcs_bin2gray(fall_cnt_reg + 1'b1);
            if (idx_next < adcs_cnt_t'(NBITS)) // [RULE_08] [RULE_11]
            begin
                sdo_fall_reg <= word_reg[4'(NBITS - 1) - idx_next[3:0]];
            end
            else
            begin
                sdo_fall_reg <= 1'b0;
            end
        end
    end

    // Edge count into the system domain
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            gray_s1_reg <= '0;
            gray_s2_reg <= '0;
        end
        else
        begin
            gray_s1_reg <= fall_gray_reg;
            gray_s2_reg <= gray_s1_reg;
        end
    end

    assign falls = adcs_gray2bin(gray_s2_reg) - base_reg;

    // Base taken when a result becomes ready; SCK is quiet then
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            base_reg <= '0;
            msb_reg <= 1'b0;
        end
        else if (state_reg == ADCS_CONVERT && conv_cnt_reg == '0)
        begin
            base_reg <= adcs_gray2bin(gray_s2_reg);
            msb_reg <= sample_reg[NBITS-1]; // [RULE_06]
        end
    end

    // Drive while selected and bits remain
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            oe_n_reg <= 1'b1;
        end
        else
        begin
            oe_n_reg <= !(state_reg == ADCS_READY // [RULE_06] [RULE_07]
                          && (!strb_s2_reg || !sdi_s2_reg)
                          && falls < adcs_cnt_t'(NBITS));
        end
    end

    // MSB until the first falling edge, shifted bits after it
    assign sdo_o.data = (fall_cnt_reg != base_reg) ? sdo_fall_reg : msb_reg;
    assign sdo_o.oe_n = oe_n_reg;

    a_conv_latency: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        strb_rise && state_reg != ADCS_CONVERT
        |=> conv_busy_o ##CONV_C result_ready_o) // [RULE_01]
        else $error("result not ready after conversion time");

    a_sdo_enable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        result_ready_o && !strb_s2_reg && falls == '0
        |=> !sdo_o.oe_n) // [RULE_06]
        else $error("SDO not driven when selected");

    a_sdo_msb: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !sdo_o.oe_n && falls == '0 && fall_cnt_reg == base_reg
        |-> sdo_o.data == word_reg[NBITS-1]) // [RULE_06]
        else $error("MSB not presented first");

    a_sdo_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        strb_s2_reg && sdi_s2_reg |=> sdo_o.oe_n) // [RULE_07]
        else $error("SDO not released on deselect");

    a_sdo_done: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        falls >= adcs_cnt_t'(NBITS) |=> sdo_o.oe_n) // [RULE_07]
        else $error("SDO still driven after last bit");

    a_bit_order: assert property (@(negedge sck_i) disable iff (rst_sck_s2_reg)
        idx_next < adcs_cnt_t'(NBITS) |=> sdo_fall_reg ==
        $past(word_reg[4'(NBITS - 1) - idx_next[3:0]])) // [RULE_08] [RULE_11]
        else $error("serial bit out of order");

    c_conversion: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        conv_busy_o ##1 result_ready_o);
    c_full_readout: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        !sdo_o.oe_n ##[1:200] falls == adcs_cnt_t'(NBITS));
    c_underrun: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        underrun_o);
endmodule

// >>> rtl/adcs_cfg.svh
/*
 * Timing counts, widths and depths of the converter readout block.
 * Assumes a 200 MHz system clock; counts derive from the period below.
 */
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

`define ADCS_CLK_PERIOD_NS 5
`define ADCS_CONV_TIME_NS 290
`define ADCS_CONV_MIN_NS 270
`define ADCS_CONV_MAX_NS 320
`define ADCS_CONV_CYCLES \
    ((`ADCS_CONV_TIME_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS)
`define ADCS_RESULT_BITS 16
`define ADCS_CNT_BITS 5
`define ADCS_FIFO_DEPTH 8

`endif

// >>> rtl/adcs_pkg.sv
/*
 * Types shared by the converter readout block, its host model and its bench.
 * Assumes adcs_cfg.svh is on the include path.
 */
`include "adcs_cfg.svh"

package adcs_pkg;

    typedef logic [`ADCS_RESULT_BITS-1:0] adcs_word_t;
    typedef logic [`ADCS_CNT_BITS-1:0] adcs_cnt_t;

    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_CONVERT,
        ADCS_READY
    } adcs_conv_e;

    // Pins driven by the host
    typedef struct packed {
        logic conversion_strobe;
        logic sdi;
    } adcs_pins_s;

    // Serial data output, enable low while driving
    typedef struct packed {
        logic data;
        logic oe_n;
    } adcs_sdo_s;

    function automatic adcs_cnt_t adcs_bin2gray(input adcs_cnt_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic adcs_cnt_t adcs_gray2bin(input adcs_cnt_t g);
        adcs_cnt_t b;
        b = g;
        for (int i = `ADCS_CNT_BITS - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// >>> rtl/adcs_fifo.sv
/*
 * Sample FIFO with valid/ready on both sides; storage in flip-flops.
 * Assumes one clock for both sides and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module adcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> testbench/adcs_host.sv
/*
 * Host serial controller model: strobe, SDI and SCK out, SDO in.
 * Assumes the bench resolves the SDO wire and calls tasks on clock edges.
 */
`timescale 1ns/100ps

module adcs_host (
    // Pins towards the device
    output adcs_pkg::adcs_pins_s pins_o,
    output logic sck_o,
    // Resolved serial data
    input wire logic sdo_i
);
    import adcs_pkg::*;

    // SDI held high so the strobe alone selects; SCK idles low
    initial
    begin
        pins_o.conversion_strobe = 1'h0;
        pins_o.sdi = 1'h1;
        sck_o = 1'h0;
    end

    task automatic strobe_rise();
        pins_o.conversion_strobe = 1'h1;
    endtask

    task automatic clocks(input int n, input realtime half);
        repeat (n)
        begin
            sck_o = 1'h1;
            #(half);
            sck_o = 1'h0;
            #(half);
        end
    endtask

    // Selects by ending the strobe pulse, or by dropping SDI when by_sdi, then shifts the word in
    task automatic read(input realtime half, input logic by_sdi,
        output adcs_word_t w);
        if (by_sdi)
            pins_o.sdi = 1'h0;
        else
            pins_o.conversion_strobe = 1'h0;
        #30; // first SCK rise far past the quiet time
        w[15] = sdo_i;
        for (int k = 14; k >= 0; k--)
        begin
            clocks(1, half);
            w[k] = sdo_i;
        end
        clocks(1, half); // Last fall closes the frame
        pins_o.sdi = 1'h1;
        pins_o.conversion_strobe = 1'h0;
    endtask
endmodule

// >>> testbench/tb.sv
/*
 * Self-checking bench: fills the sample FIFO, drains it by conversions.
 * Assumes the design's assertions sit inside the design files.
 */
`timescale 1ns/100ps

module tb;
    import adcs_pkg::*;

    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic sample_valid_i = 1'h0;
    adcs_word_t sample_data_i = 16'h0000;
    logic sample_ready_o;
    logic conv_busy_o;
    logic result_ready_o;
    logic underrun_o;
    logic sck;
    logic sdo_last = 1'h0;
    wire sdo_w;
    adcs_pins_s pins;
    adcs_sdo_s sdo;
    int err_count = 0;
    int n_tests = 0;
    adcs_word_t wd [8];

    always #2.5 clk_sys_i = ~clk_sys_i;

    // Released line shows the inverse of its last driven value
    always @*
    begin
        if (!sdo.oe_n)
            sdo_last = sdo.data;
    end
    assign sdo_w = sdo.oe_n ? ~sdo_last : sdo.data;

    adcs_top #(.FIFO_DEPTH(8)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sck_i(sck),
        .pins_i(pins), .sdo_o(sdo), .sample_valid_i(sample_valid_i),
        .sample_data_i(sample_data_i), .sample_ready_o(sample_ready_o),
        .conv_busy_o(conv_busy_o), .result_ready_o(result_ready_o),
        .underrun_o(underrun_o));

    adcs_host host (.pins_o(pins), .sck_o(sck), .sdo_i(sdo_w));

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk_word(input adcs_word_t got, input adcs_word_t exp);
        n_tests++;
        if (got !== exp)
            fail($sformatf("word %h, expected %h", got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
            fail(m);
    endtask

    task automatic chk_span(input int n, input int lo, input int hi);
        n_tests++;
        if (n < lo || n > hi)
            fail($sformatf("conversion took %0d cycles", n));
    endtask

    // Fill the FIFO until it refuses
    task automatic s_fill();
        for (int i = 0; i < 8; i++)
        begin
            wd[i] = 16'h8001 + adcs_word_t'(16'h2357 * i);
            @(negedge clk_sys_i);
            chk_bit(sample_ready_o, 1'h1, "fifo refused early");
            sample_data_i = wd[i];
            sample_valid_i = 1'h1;
            @(negedge clk_sys_i);
            sample_valid_i = 1'h0;
        end
        @(negedge clk_sys_i);
        chk_bit(sample_ready_o, 1'h0, "full fifo still ready");
    endtask

    // One conversion and readout, timing and word judged
    task automatic s_conv(input adcs_word_t exp, input realtime half,
        input logic under, input logic by_sdi);
        int n;
        logic seen;
        adcs_word_t w;
        n = 0;
        seen = 1'h0;
        @(negedge clk_sys_i);
        host.strobe_rise();
        while (conv_busy_o !== 1'h1 && n < 8)
        begin
            @(negedge clk_sys_i);
            seen |= (underrun_o === 1'h1);
            n++;
        end
        chk_bit(sdo.oe_n, 1'h1, "sdo driven in conversion");
        while (result_ready_o !== 1'h1 && n < 100)
        begin
            @(negedge clk_sys_i);
            seen |= (underrun_o === 1'h1);
            n++;
        end
        chk_span(n, 54, 64);
        chk_bit(seen, under, "underrun flag wrong");
        host.read(half, by_sdi, w);
        chk_word(w, exp);
        repeat (6) @(negedge clk_sys_i);
        chk_bit(sdo.oe_n, 1'h1, "sdo not released");
        repeat (14) @(negedge clk_sys_i);
    endtask

    initial
    begin
        fork
            repeat (4) @(negedge clk_sys_i);
            host.clocks(4, 2.5);
        join
        rst_i = 1'h0;
        // Link-domain reset lasts two more SCK falls after release
        host.clocks(2, 5.0);
        @(negedge clk_sys_i);
        s_fill();
        // Odd runs use the slow daisy-chain SCK, even runs the fast one
        for (int i = 0; i < 8; i++)
            s_conv(wd[i], (i % 2) ? 20.0 : 7.5, 1'h0, i > 5);
        s_conv(wd[7], 7.5, 1'h1, 1'h0);
        end_sim();
    end

    initial
    begin
        #30000;
        fail("watchdog expired");
        end_sim();
    end
endmodule
